// ### logic/acps_ctrl.v
`timescale 1ns/1ps
// What this block does
// - bits 7,6,2,1,0 of control word ignored
// - bits 5..3 pick next conversion's channel
// - address decodes as plain binary input index
// - powered up on frame select fall, down while high
// - continuous mode: power down after 16th fall
// - sixteen clocks per conversion, back to back
// - any idle gap length, next frame still works
// - control word taken on first 8 rises, msb first
// - falls 1-4 send zeros, 5-16 send result
`include "acps_consts.vh"
module acps_ctrl
(
   input  wire                     clock,            // system clock, 25 MHz
   input  wire                     reset_n,          // async reset, active low
   input  wire                     frame_select_n,   // host frame select pin
   input  wire                     serial_clock,     // host serial clock pin
   input  wire                     serial_in,        // host serial data pin
   output wire                     serial_out,       // serial data out
   output wire                     serial_out_oe_n,  // low while driving
   output reg  [`ACPS_ADDR_W-1:0]  chan_select,      // analog mux index
   output reg                      powered,          // converter powered
   output reg                      tracking,         // track phase active
   output wire                     result_ready,     // buffer wants a result
   input  wire                     result_valid,     // converter result valid
   input  wire [`ACPS_RES_W-1:0]   result_data,      // converter result
   output wire                     word_valid,       // captured word valid
   input  wire                     word_ready,       // user takes word
   output wire [`ACPS_WORD_W-1:0]  word_data         // captured control word
);

   // three-stage samplers for pins
   reg [2:0] fs_sync_reg;
   reg [2:0] sck_sync_reg;
   reg [2:0] sdi_sync_reg;
   reg       fs_reg;                               // filtered frame select
   reg       sck_reg;                              // filtered serial clock
   reg       sdi_reg;                              // filtered serial data

   // pin samplers: change counts once stages 2 and 3 agree
   always @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         fs_sync_reg  <= `ACPS_SYNC_HIGH;
         sck_sync_reg <= `ACPS_SYNC_HIGH;  // serial clock idles high, no false rise
         sdi_sync_reg <= `ACPS_SYNC_LOW;
         fs_reg       <= 1'b1;
         sck_reg      <= 1'b1;
         sdi_reg      <= 1'b0;
      end
      else
      begin
         fs_sync_reg  <= {fs_sync_reg[1:0], frame_select_n};
         sck_sync_reg <= {sck_sync_reg[1:0], serial_clock};
         sdi_sync_reg <= {sdi_sync_reg[1:0], serial_in};
         if (fs_sync_reg[1] == fs_sync_reg[2])
            fs_reg <= fs_sync_reg[2];
         if (sck_sync_reg[1] == sck_sync_reg[2])
            sck_reg <= sck_sync_reg[2];
         if (sdi_sync_reg[1] == sdi_sync_reg[2])
            sdi_reg <= sdi_sync_reg[2];
      end
   end

   // edge detection on filtered signals
   wire sck_rise   = (sck_sync_reg[1] == sck_sync_reg[2]) & sck_sync_reg[2] & ~sck_reg;
   wire sck_fall   = (sck_sync_reg[1] == sck_sync_reg[2]) & ~sck_sync_reg[2] & sck_reg;
   wire frame_on   = ~fs_reg;                      // frame active
   wire frame_fall = (fs_sync_reg[1] == fs_sync_reg[2]) & ~fs_sync_reg[2] & fs_reg;

   // frame state
   reg [`ACPS_CNT_W-1:0]  rise_cnt_reg;            // rises in conversion
   reg [`ACPS_CNT_W-1:0]  fall_cnt_reg;            // falls in conversion
   reg [`ACPS_WORD_W-1:0] shift_in_reg;            // incoming control word
   reg [`ACPS_ADDR_W-1:0] addr_latch_reg;          // held address
   reg [`ACPS_RES_W-1:0]  shift_out_reg;           // outgoing result
   reg                    sdo_reg;                 // serial out bit
   reg                    word_push;               // word complete pulse
   reg                    conv_done_reg;           // after 16th fall

   // two-entry buffer for converter results, head read at fourth fall
   reg [`ACPS_RES_W-1:0]  rbuf_mem [0:`ACPS_BUF_DEPTH-1];
   reg                    rwr_ptr_reg;
   reg                    rrd_ptr_reg;
   reg [1:0]              rcount_reg;
   wire [`ACPS_RES_W-1:0] buf_head = (rcount_reg == 2'h0) ? `ACPS_RES_ZERO : rbuf_mem[rrd_ptr_reg];

   // conversion sequencing, clocked only within a frame
   always @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rise_cnt_reg   <= `ACPS_CNT_ZERO;
         fall_cnt_reg   <= `ACPS_CNT_ZERO;
         shift_in_reg   <= `ACPS_WORD_ZERO;
         addr_latch_reg <= `ACPS_CHAN_RESET;
         shift_out_reg  <= `ACPS_RES_ZERO;
         sdo_reg        <= 1'b0;
         word_push      <= 1'b0;
         conv_done_reg  <= 1'b0;
         chan_select    <= `ACPS_CHAN_RESET;
         powered        <= 1'b0;
         tracking       <= 1'b0;
      end
      else
      begin
         word_push <= 1'b0;
         if (!frame_on & ~frame_fall)
         begin
            // frame select high: full power-down, counters cleared
            rise_cnt_reg  <= `ACPS_CNT_ZERO;
            fall_cnt_reg  <= `ACPS_CNT_ZERO;
            conv_done_reg <= 1'b0;
            powered       <= 1'b0;
            tracking      <= 1'b0;
            sdo_reg       <= 1'b0;
         end
         else
         begin
            if (frame_fall & (~sck_reg | sck_fall))
            begin
               // frame start with clock low, or falling with it, counts as first fall
               fall_cnt_reg <= `ACPS_CNT_ONE;
               chan_select  <= addr_latch_reg;
               powered      <= 1'b1;
               tracking     <= 1'b1;
               sdo_reg      <= 1'b0;
            end
            else if (frame_fall)
               powered <= 1'b1;
            if (sck_rise)
            begin
               if (rise_cnt_reg < `ACPS_CTRL_EDGES)
               begin
                  shift_in_reg <= {shift_in_reg[`ACPS_WORD_W-2:0], sdi_reg};
                  if (rise_cnt_reg == `ACPS_CTRL_EDGES - `ACPS_CNT_ONE)
                  begin
                     addr_latch_reg <= shift_in_reg[`ACPS_ADDR_HI-1:`ACPS_ADDR_LO-1];
                     word_push      <= 1'b1;
                  end
               end
               if (rise_cnt_reg == `ACPS_CONV_EDGES - `ACPS_CNT_ONE)
                  rise_cnt_reg <= `ACPS_CNT_ZERO;
               else
                  rise_cnt_reg <= rise_cnt_reg + `ACPS_CNT_ONE;
            end
            if (sck_fall & ~(frame_fall))
            begin
               if ((fall_cnt_reg == `ACPS_CNT_ZERO) | conv_done_reg)
               begin
                  // first fall of a conversion: wake and track
                  fall_cnt_reg  <= `ACPS_CNT_ONE;
                  conv_done_reg <= 1'b0;
                  powered       <= 1'b1;
                  tracking      <= 1'b1;
                  chan_select   <= addr_latch_reg;
                  sdo_reg       <= 1'b0;
               end
               else
               begin
                  fall_cnt_reg <= fall_cnt_reg + `ACPS_CNT_ONE;
                  if (fall_cnt_reg == `ACPS_ZERO_FALLS - `ACPS_CNT_ONE)
                  begin
                     tracking      <= 1'b0;       // hold from fourth fall
                     sdo_reg       <= 1'b0;
                     shift_out_reg <= buf_head;
                  end
                  else if (fall_cnt_reg < `ACPS_ZERO_FALLS)
                     sdo_reg <= 1'b0;
                  else
                  begin
                     sdo_reg       <= shift_out_reg[`ACPS_RES_W-1];
                     shift_out_reg <= {shift_out_reg[`ACPS_RES_W-2:0], 1'b0};
                     if (fall_cnt_reg == `ACPS_CONV_EDGES - `ACPS_CNT_ONE)  // sixteenth fall
                     begin
                        conv_done_reg <= 1'b1;
                        powered       <= 1'b0;
                     end
                  end
               end
            end
         end
      end
   end

   // result buffer handshake: pop on fourth fall, push on valid and ready
   wire rpop  = sck_fall & frame_on & (fall_cnt_reg == `ACPS_ZERO_FALLS - `ACPS_CNT_ONE)
                & (rcount_reg != 2'h0) & ~conv_done_reg;
   assign result_ready = (rcount_reg != 2'h2);
   wire rpush = result_valid & result_ready;

   // result buffer pointers and storage
   always @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rwr_ptr_reg <= 1'b0;
         rrd_ptr_reg <= 1'b0;
         rcount_reg  <= 2'h0;
      end
      else
      begin
         if (rpush)
            rwr_ptr_reg <= ~rwr_ptr_reg;
         if (rpop)
            rrd_ptr_reg <= ~rrd_ptr_reg;
         rcount_reg <= rcount_reg + {1'b0, rpush} - {1'b0, rpop};
      end
   end

   // storage write, no reset needed
   always @(posedge clock)
   begin
      if (rpush)
         rbuf_mem[rwr_ptr_reg] <= result_data;
   end

   // two-entry buffer for captured control words
   reg [`ACPS_WORD_W-1:0] wbuf_mem [0:`ACPS_BUF_DEPTH-1];
   reg                    wwr_ptr_reg;
   reg                    wrd_ptr_reg;
   reg [1:0]              wcount_reg;
   wire wpush = word_push & (wcount_reg != 2'h2);
   wire wpop  = word_valid & word_ready;
   assign word_valid = (wcount_reg != 2'h0);
   assign word_data  = wbuf_mem[wrd_ptr_reg];

   // word buffer pointers
   always @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wwr_ptr_reg <= 1'b0;
         wrd_ptr_reg <= 1'b0;
         wcount_reg  <= 2'h0;
      end
      else
      begin
         if (wpush)
            wwr_ptr_reg <= ~wwr_ptr_reg;
         if (wpop)
            wrd_ptr_reg <= ~wrd_ptr_reg;
         wcount_reg <= wcount_reg + {1'b0, wpush} - {1'b0, wpop};
      end
   end

   // word storage
   always @(posedge clock)
   begin
      if (wpush)
         wbuf_mem[wwr_ptr_reg] <= shift_in_reg;  // whole word, one cycle after eighth rise
   end

   // output enable follows frame select
   assign serial_out      = sdo_reg;
   assign serial_out_oe_n = ~frame_on;

endmodule

// ### logic/acps_consts.vh
`ifndef ACPS_CONSTS_VH
`define ACPS_CONSTS_VH
// control word layout
`define ACPS_WORD_W        8
`define ACPS_ADDR_HI       5
`define ACPS_ADDR_LO       3
`define ACPS_ADDR_W        3
// conversion framing
`define ACPS_CONV_EDGES    5'h10
`define ACPS_CTRL_EDGES    5'h08
`define ACPS_ZERO_FALLS    5'h04
`define ACPS_RES_W         12
`define ACPS_CNT_W         5
`define ACPS_CNT_ZERO      5'h00
`define ACPS_CNT_ONE       5'h01
// buffer
`define ACPS_BUF_DEPTH     2
`define ACPS_CHAN_RESET    3'h0
`define ACPS_RES_ZERO      12'h000
`define ACPS_WORD_ZERO     8'h00
// pin sampler idle levels
`define ACPS_SYNC_HIGH     3'h7
`define ACPS_SYNC_LOW      3'h0
`endif

// ### test/acps_host.sv
`timescale 1ns/1ps
// host model: frames, serial clock idle high, words msb first
module acps_host
(
   input  wire       clock,
   input  wire       serial_out,
   input  wire [2:0] chan_select,
   output reg        frame_select_n,
   output reg        serial_clock,
   output reg        serial_in
);
   initial {frame_select_n, serial_clock, serial_in} = 3'b110;
   task automatic wait_n(input integer n);
      repeat (n) @(posedge clock);
   endtask
   // one conversion of sixteen serial clocks
   task automatic conv(input [7:0] w, output [15:0] r, output [2:0] c);
      integer i;
      for (i = 0; i < 16; i++)
      begin
         serial_clock <= 1'b0;
         serial_in <= (i < 8) ? w[7-i] : ~serial_in;
         wait_n(4);
         serial_clock <= 1'b1;
         wait_n(4);
         r = {r[14:0], serial_out};
         if (i == 1) c = chan_select;
      end
   endtask
   task automatic open_frame();
      frame_select_n <= 1'b0;
      wait_n(4);
   endtask
   // frame start with serial clock dropped at the same edge
   task automatic open_frame_low();
      serial_clock <= 1'b0;
      frame_select_n <= 1'b0;
      wait_n(4);
   endtask
   task automatic close_frame();
      frame_select_n <= 1'b1;
      wait_n(12);
   endtask
endmodule

// ### test/acps_ctrl_properties.sv
`timescale 1ns/1ps
`include "acps_consts.vh"
module acps_ctrl_properties
(
   input wire                    clock,
   input wire                    reset_n,
   input wire                    frame_select_n,
   input wire                    serial_out,
   input wire                    serial_out_oe_n,
   input wire [`ACPS_ADDR_W-1:0] chan_select,
   input wire                    powered,
   input wire                    tracking,
   input wire                    word_valid,
   input wire                    word_ready,
   input wire [`ACPS_WORD_W-1:0] word_data
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   a_idle_off: assert property (frame_select_n [*8] |-> serial_out_oe_n && !powered)
      else $error("idle not off");
   a_frame_drive: assert property (!frame_select_n [*8] |-> !serial_out_oe_n)
      else $error("frame not driven");
   a_frame_power: assert property ($fell(frame_select_n) |-> ##[4:6] powered)
      else $error("frame not powered");
   a_track_powered: assert property (tracking |-> powered)
      else $error("track unpowered");
   a_gap_down: assert property ($fell(powered) && !frame_select_n |-> !powered [*4])
      else $error("gap power early");
   a_track_span: assert property ($rose(tracking) |-> tracking [*8] ##[1:30] !tracking)
      else $error("track length");
   a_lead_zero: assert property (tracking && $past(tracking, 5) |-> !serial_out)
      else $error("lead bit not zero");
   a_chan_hold: assert property (!$rose(tracking) |-> $stable(chan_select))
      else $error("chan moved");
   a_word_hold: assert property (word_valid && !word_ready |=> word_valid && $stable(word_data))
      else $error("stalled word changed");
endmodule
bind acps_ctrl acps_ctrl_properties i_props (.clock(clock), .reset_n(reset_n), .frame_select_n(frame_select_n),
   .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n), .chan_select(chan_select), .powered(powered),
   .tracking(tracking), .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data));

// ### test/adc_channel_select_power_ctrl_bench.sv
`timescale 1ns/1ps
`define CHECK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; $display("[ERR] %0t %h %h", $time, a, b); end end
module adc_channel_select_power_ctrl_bench;
   reg         clock = 0, reset_n = 0, result_valid = 0, word_ready = 0, stall = 0;
   reg  [11:0] result_data = 0;
   wire        frame_select_n, serial_clock, serial_in, serial_out, oe_n, powered, tracking, result_ready, word_valid;
   wire [2:0]  chan_select;
   wire [7:0]  word_data;
   reg  [7:0]  wq, prev = 0, exp_w [$];
   reg  [11:0] res_q [$];
   reg  [15:0] r;
   reg  [2:0]  c;
   reg  [31:0] v;
   integer     n_fail = 0, n_compared = 0, seed = 32'h390e_5f90, cyc = 0, k;
   always #20 clock = ~clock;
   acps_ctrl i_dut (.clock(clock), .reset_n(reset_n), .frame_select_n(frame_select_n),
      .serial_clock(serial_clock), .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe_n(oe_n),
      .chan_select(chan_select), .powered(powered), .tracking(tracking), .result_ready(result_ready),
      .result_valid(result_valid), .result_data(result_data), .word_valid(word_valid),
      .word_ready(word_ready), .word_data(word_data));
   acps_host i_host (.clock(clock), .serial_out(serial_out), .chan_select(chan_select),
      .frame_select_n(frame_select_n), .serial_clock(serial_clock), .serial_in(serial_in));
   task tally_and_finish;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // offer one result, refused if the buffer is full
   task push(input [11:0] d, input ok_exp);
      reg ok;
      ok = 0;
      result_valid <= 1'b1;
      result_data <= d;
      repeat (4) if (!ok)
      begin
         @(posedge clock);
         ok = (result_ready === 1'b1);
      end
      result_valid <= 1'b0;
      if (ok) res_q.push_back(d);
      @(posedge clock);
      `CHECK(ok, ok_exp)
   endtask
   // one conversion: channel from the previous word, zeros then result
   task conv1(input [7:0] wd);
      reg [15:0] e;
      e = {4'h0, res_q.size() ? res_q.pop_front() : 12'h000};
      exp_w.push_back(wd);
      i_host.conv(wd, r, c);
      `CHECK(c, prev[5:3])
      `CHECK(r, e)
      prev = wd;
   endtask
   // word sink with random stalls, and the run limit
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      word_ready <= !stall && $random(seed) % 2;
      if (word_valid === 1'b1 && word_ready === 1'b1)
      begin
         wq = exp_w.pop_front();
         `CHECK(word_data, wq)
      end
      if (cyc == 30000)
      begin
         n_fail++;
         tally_and_finish();
      end
   end
   initial
   begin
      repeat (16) @(posedge clock);
      reset_n <= 1'b1;
      repeat (4) @(posedge clock);
      i_host.open_frame();
      for (k = 0; k < 8; k++)
      begin
         v = $random(seed);
         push(v[23:12], 1'b1);
         conv1({v[7:6], k[2:0], v[2:0]});
      end
      i_host.close_frame();
      $display("channel sweep done");
      repeat (500) @(posedge clock);
      i_host.open_frame_low();
      push(12'hfff, 1'b1);
      conv1(8'hc7);
      i_host.close_frame();
      $display("idle gap done");
      stall <= 1'b1;
      push(12'ha5a, 1'b1);
      push(12'h5a5, 1'b1);
      push(12'h123, 1'b0);
      i_host.open_frame();
      conv1(8'h38);
      conv1(8'h10);
      conv1(8'h28);
      i_host.close_frame();
      wq = exp_w.pop_back();
      stall <= 1'b0;
      repeat (20) @(posedge clock);
      `CHECK(exp_w.size(), 0)
      $display("buffer full done");
      tally_and_finish();
   end
endmodule
